// ==== design/servo_trace_capture.sv ====
`timescale 1ns/100ps
module servo_trace_capture #(
  parameter int unsigned NUM_AXES    = 5,
  parameter int unsigned DATA_W      = trace_pkg::DATA_W,
  parameter int unsigned TICK_CYCLES = trace_pkg::TICK_CYCLES
) (
  input  wire logic                              sys_clk,
  input  wire logic                              nrst,
  input  wire logic [4:0]                        reg_addr,
  input  wire logic [31:0]                       reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [31:0]                       reg_rdata,
  input  wire logic [NUM_AXES*trace_pkg::NUM_SRC*DATA_W-1:0] servo_vals,
  input  wire logic                              ext_trigger,
  output logic      [trace_pkg::NUM_CH-1:0]      chan_visible,
  output logic      [NUM_AXES-1:0]               step_axes,
  output logic      [DATA_W-1:0]                 step_amplitude,
  output logic                                   recording,
  output logic                                   sample_strobe
);
  localparam int unsigned NC = trace_pkg::NUM_CH;
  localparam int unsigned AW = trace_pkg::IDX_W;
  localparam int unsigned TW = $clog2(TICK_CYCLES);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FILL  = 3'b001,
    ST_ARMED = 3'b010,
    ST_POST  = 3'b011,
    ST_DONE  = 3'b100
  } state_t;

  // register file
  trace_pkg::mode_cfg_t  mode_q;
  trace_pkg::chan_cfg_t  chcfg_q [NC];
  logic [5:0]            period_q;
  logic [DATA_W-1:0]     thresh_q;
  logic [DATA_W-1:0]     feed_q;
  logic [NUM_AXES-1:0]   digax_q;
  logic [AW-1:0]         cur1_q;
  logic [1:0]            cur_ch_q;
  logic [AW-1:0]         cur2_q;
  logic [2:0]            zoom_q;
  logic [AW-1:0]         win_start_q;
  logic [31:0]           rdata_q;

  // capture state
  state_t                state_q;
  logic [TW-1:0]         base_cnt_q;
  logic [5:0]            per_cnt_q;
  logic [AW-1:0]         wr_idx_q;
  logic [12:0]           cnt_q;
  logic [AW-1:0]         trig_idx_q;
  logic                  valid_q;
  logic                  have_prev_q;
  logic [DATA_W-1:0]     prev_q;
  logic                  ext_req_q;
  logic                  strobe_q;

  // readout
  logic [31:0]           t1_time_q;
  logic [DATA_W-1:0]     t1_val_q;
  logic [31:0]           t2_time_q;
  logic [DATA_W-1:0]     t2_val_q;
  logic [12:0]           win_len_q;
  logic [NC-1:0]         vis_q;
  logic [NUM_AXES-1:0]   step_q;
  logic [DATA_W-1:0]     amp_q;

  function automatic logic [DATA_W-1:0] pick(input logic [NC*DATA_W-1:0] w,
                                             input logic [1:0] ch);
    return w[ch*DATA_W +: DATA_W];
  endfunction

  // write decode
  wire wr_ctrl   = reg_wr && (reg_addr == trace_pkg::A_CTRL);
  wire do_start  = wr_ctrl && reg_wdata[trace_pkg::CTRL_START];
  wire do_stop   = wr_ctrl && reg_wdata[trace_pkg::CTRL_STOP];
  wire do_disc   = wr_ctrl && reg_wdata[trace_pkg::CTRL_DISCARD];
  wire active    = (state_q == ST_FILL) || (state_q == ST_ARMED) || (state_q == ST_POST);

  // interval clamp to 0.6 .. 6 ms
  wire [5:0] per_in = (reg_wdata[5:0] < trace_pkg::PERIOD_MIN) ? trace_pkg::PERIOD_MIN :
                      (reg_wdata[5:0] > trace_pkg::PERIOD_MAX) ? trace_pkg::PERIOD_MAX :
                      reg_wdata[5:0];
  wire [2:0] zoom_in = (reg_wdata[2:0] > trace_pkg::ZOOM_MAX) ? trace_pkg::ZOOM_MAX :
                       reg_wdata[2:0];

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mode_q      <= trace_pkg::mode_cfg_t'(trace_pkg::MODE_RESET);
      period_q    <= trace_pkg::PERIOD_RESET;
      thresh_q    <= '0;
      feed_q      <= '0;
      digax_q     <= '0;
      cur1_q      <= '0;
      cur_ch_q    <= '0;
      cur2_q      <= '0;
      zoom_q      <= '0;
      win_start_q <= '0;
      for (int i = 0; i < NC; i++) begin
        chcfg_q[i] <= '{axis: 3'h0, src: trace_pkg::SRC_OFF};
      end
    end else if (reg_wr) begin
      case (reg_addr)
        trace_pkg::A_MODE:   mode_q   <= trace_pkg::mode_cfg_t'(reg_wdata[10:0]);
        trace_pkg::A_PERIOD: period_q <= per_in;
        trace_pkg::A_THRESH: thresh_q <= reg_wdata[DATA_W-1:0];
        trace_pkg::A_FEED:   feed_q   <= reg_wdata[DATA_W-1:0];
        trace_pkg::A_DIGAX:  digax_q  <= reg_wdata[NUM_AXES-1:0];
        trace_pkg::A_CUR1: begin
          cur1_q   <= reg_wdata[AW-1:0];
          cur_ch_q <= reg_wdata[17:16];
        end
        trace_pkg::A_CUR2:   cur2_q   <= reg_wdata[AW-1:0];
        trace_pkg::A_ZOOM: begin
          zoom_q      <= zoom_in;
          win_start_q <= reg_wdata[16 +: AW];
        end
        default: begin
          for (int i = 0; i < NC; i++) begin
            if (reg_addr == trace_pkg::A_CHCFG0 + 5'(i)) begin
              chcfg_q[i] <= '{axis: reg_wdata[2:0], src: trace_pkg::src_t'(reg_wdata[7:4])};
            end
          end
        end
      endcase
    end
  end

  // sample clock: 0.1 ms base enable, then interval count
  wire base_tick   = (base_cnt_q == TW'(TICK_CYCLES - 1));
  wire sample_tick = base_tick && (per_cnt_q >= period_q - 6'h01);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      base_cnt_q <= '0;
      per_cnt_q  <= '0;
    end else begin
      base_cnt_q <= base_tick ? '0 : base_cnt_q + TW'(1);
      if (base_tick) begin
        per_cnt_q <= sample_tick ? 6'h00 : per_cnt_q + 6'h01;
      end
    end
  end

  logic [NC*DATA_W-1:0] samp;
  logic [NC-1:0]        lane_we;
  always_comb begin
    samp    = '0;
    lane_we = '0;
    for (int i = 0; i < NC; i++) begin
      if (chcfg_q[i].src != trace_pkg::SRC_OFF && chcfg_q[i].src != trace_pkg::SRC_SAVED
          && chcfg_q[i].src <= trace_pkg::SRC_ANALOGUE
          && 32'(chcfg_q[i].axis) < NUM_AXES) begin
        samp[i*DATA_W +: DATA_W] = servo_vals[(32'(chcfg_q[i].axis) * trace_pkg::NUM_SRC
                                   + 32'(chcfg_q[i].src) - 1) * DATA_W +: DATA_W];
        lane_we[i] = 1'b1;
      end
    end
  end

  // threshold compared in the trigger channel's own unit
  wire [DATA_W-1:0] trig_val = pick(samp, mode_q.trig_ch);
  wire above_now  = $signed(trig_val) >= $signed(thresh_q);
  wire above_prev = $signed(prev_q) >= $signed(thresh_q);
  wire crossed    = have_prev_q && (mode_q.falling ? (above_prev && !above_now)
                                                   : (!above_prev && above_now));
  // one_trigger_capture fires on the external trigger request
  wire trig_hit   = (mode_q.mode == trace_pkg::TRIG_SINGLE) ? ext_req_q :
                    (mode_q.mode == trace_pkg::TRIG_CHAN) ? crossed : 1'b0;

  wire [12:0] pre_cnt  = (mode_q.pre_code > 3'h4) ? trace_pkg::FULL :
                         13'(mode_q.pre_code) * trace_pkg::QUARTER;
  wire [12:0] post_cnt = trace_pkg::FULL - pre_cnt;
  wire        write_en = sample_tick && active;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q     <= ST_IDLE;
      wr_idx_q    <= '0;
      cnt_q       <= '0;
      trig_idx_q  <= '0;
      valid_q     <= 1'b0;
      have_prev_q <= 1'b0;
      prev_q      <= '0;
      ext_req_q   <= 1'b0;
      strobe_q    <= 1'b0;
    end else begin
      strobe_q <= write_en;
      // a request arriving as it is consumed is kept
      ext_req_q <= ext_trigger || (ext_req_q && !(sample_tick && state_q == ST_ARMED));
      if (sample_tick) begin
        prev_q      <= trig_val;
        have_prev_q <= active;
      end
      if (write_en) begin
        wr_idx_q <= wr_idx_q + AW'(1);
      end
      if (do_start) begin
        wr_idx_q    <= '0;
        cnt_q       <= '0;
        trig_idx_q  <= '0;
        valid_q     <= 1'b0;
        have_prev_q <= 1'b0;
        ext_req_q   <= ext_trigger;
        // free run goes straight to recording
        if (mode_q.mode == trace_pkg::TRIG_FREE) begin
          state_q <= ST_POST;
        end else if (pre_cnt == 13'h0000) begin
          state_q <= ST_ARMED;
        end else begin
          state_q <= ST_FILL;
        end
      end else if (do_stop && active) begin
        state_q <= ST_DONE;
        valid_q <= 1'b1;
      end else if (do_disc) begin
        state_q <= ST_IDLE;
        valid_q <= 1'b0;
      end else if (sample_tick) begin
        case (state_q)
          ST_FILL: begin
            cnt_q <= cnt_q + 13'h0001;
            if (cnt_q == pre_cnt - 13'h0001) begin
              state_q <= ST_ARMED;
            end
          end
          ST_ARMED: begin
            if (trig_hit) begin
              trig_idx_q <= wr_idx_q;
              cnt_q      <= 13'h0001;
              if (post_cnt <= 13'h0001) begin
                state_q <= ST_DONE;
                valid_q <= 1'b1;
              end else begin
                state_q <= ST_POST;
              end
            end
          end
          ST_POST: begin
            if (mode_q.mode != trace_pkg::TRIG_FREE) begin
              cnt_q <= cnt_q + 13'h0001;
              if (cnt_q == post_cnt - 13'h0001) begin
                state_q <= ST_DONE;
                valid_q <= 1'b1;
              end
            end
          end
          default: state_q <= state_q;
        endcase
      end
    end
  end

  logic [NC*DATA_W-1:0] rd_a;
  logic [NC*DATA_W-1:0] rd_b;

  capture_mem #(
    .WIDTH (DATA_W),
    .NCH   (NC),
    .AW    (AW)
  ) u_mem (
    .sys_clk   (sys_clk),
    .wr_en     (lane_we & {NC{write_en}}),
    .wr_idx    (wr_idx_q),
    .wr_data   (samp),
    .rd_idx_a  (cur1_q),
    .rd_idx_b  (cur2_q),
    .rd_data_a (rd_a),
    .rd_data_b (rd_b)
  );

  // cursor times in 0.1 ms units, signed
  wire signed [12:0] d1      = $signed({1'b0, cur1_q}) - $signed({1'b0, trig_idx_q});
  wire signed [12:0] d2      = $signed({1'b0, cur2_q}) - $signed({1'b0, cur1_q});
  wire signed [6:0]  per_s   = $signed({1'b0, period_q});
  wire signed [19:0] t1_prod = d1 * per_s;
  wire signed [19:0] t2_prod = d2 * per_s;
  wire [DATA_W-1:0]  v1      = pick(rd_a, cur_ch_q);
  wire [DATA_W-1:0]  v2      = pick(rd_b, cur_ch_q);

  // window 4096 >> zoom, start kept inside the record
  wire [12:0] win_len  = trace_pkg::FULL >> zoom_q;
  wire [12:0] win_room = trace_pkg::FULL - win_len;
  wire [AW-1:0] win_st = (13'(win_start_q) > win_room) ? win_room[AW-1:0] : win_start_q;

  // step only in manual, only on digital axes
  // mdi and auto keep the ramp
  wire step_ok = mode_q.step_sel && (mode_q.op == trace_pkg::OP_MANUAL);

  logic [NC-1:0] vis_d;
  always_comb begin
    for (int i = 0; i < NC; i++) begin
      vis_d[i] = (chcfg_q[i].src != trace_pkg::SRC_OFF) &&
                 !(chcfg_q[i].src == trace_pkg::SRC_SAVED && active);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      t1_time_q <= '0;
      t1_val_q  <= '0;
      t2_time_q <= '0;
      t2_val_q  <= '0;
      win_len_q <= trace_pkg::FULL;
      vis_q     <= '0;
      step_q    <= '0;
      amp_q     <= '0;
    end else begin
      t1_time_q <= 32'(t1_prod);
      t1_val_q  <= v1;
      t2_time_q <= 32'(t2_prod);
      t2_val_q  <= v2 - v1;
      win_len_q <= win_len;
      vis_q     <= vis_d;
      step_q    <= digax_q & {NUM_AXES{step_ok}};
      // feed rate sets the step height
      amp_q     <= step_ok ? feed_q : '0;
    end
  end

  // read mux; unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      trace_pkg::A_CTRL:   rd_mux = {29'h0, (state_q == ST_ARMED), valid_q, active};
      trace_pkg::A_MODE:   rd_mux = {21'h0, mode_q};
      trace_pkg::A_PERIOD: rd_mux = {26'h0, period_q};
      trace_pkg::A_THRESH: rd_mux = 32'(thresh_q);
      trace_pkg::A_FEED:   rd_mux = 32'(feed_q);
      trace_pkg::A_DIGAX:  rd_mux = 32'(digax_q);
      trace_pkg::A_CUR1:   rd_mux = {14'h0, cur_ch_q, 4'h0, cur1_q};
      trace_pkg::A_CUR2:   rd_mux = {20'h0, cur2_q};
      trace_pkg::A_ZOOM:   rd_mux = {4'h0, win_st, 13'h0, zoom_q};
      trace_pkg::A_TRIDX:  rd_mux = {20'h0, trig_idx_q};
      trace_pkg::A_T1TIME: rd_mux = t1_time_q;
      trace_pkg::A_T1VAL:  rd_mux = 32'(t1_val_q);
      trace_pkg::A_T2TIME: rd_mux = t2_time_q;
      trace_pkg::A_T2VAL:  rd_mux = 32'(t2_val_q);
      trace_pkg::A_WINDOW: rd_mux = {19'h0, win_len_q};
      default: begin
        for (int i = 0; i < NC; i++) begin
          if (reg_addr == trace_pkg::A_CHCFG0 + 5'(i)) begin
            rd_mux = {24'h0, chcfg_q[i].src, 1'b0, chcfg_q[i].axis};
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else begin
      // data stand for the one cycle after the strobe only
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata      = rdata_q;
  assign chan_visible   = vis_q;
  assign step_axes      = step_q;
  assign step_amplitude = amp_q;
  assign sample_strobe  = strobe_q;

  logic rec_q;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rec_q <= 1'b0;
    end else begin
      rec_q <= active;
    end
  end
  assign recording = rec_q;
endmodule

// ==== design/trace_pkg.sv ====
package trace_pkg;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned IDX_W       = 12;
  localparam int unsigned NUM_CH      = 4;
  localparam int unsigned DEPTH       = 4096;
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned TICK_US     = 100;
  localparam int unsigned TICK_CYCLES = CLK_MHZ * TICK_US;
  // interval in 0.1 ms steps
  localparam logic [5:0]  PERIOD_MIN  = 6'h06;
  localparam logic [5:0]  PERIOD_MAX  = 6'h3c;
  localparam logic [2:0]  ZOOM_MAX    = 3'h6;
  localparam logic [12:0] QUARTER     = 13'h0400;
  localparam logic [12:0] FULL        = 13'h1000;

  localparam logic [4:0] A_CTRL   = 5'h00;
  localparam logic [4:0] A_MODE   = 5'h01;
  localparam logic [4:0] A_PERIOD = 5'h02;
  localparam logic [4:0] A_THRESH = 5'h03;
  localparam logic [4:0] A_CHCFG0 = 5'h04;
  localparam logic [4:0] A_FEED   = 5'h08;
  localparam logic [4:0] A_DIGAX  = 5'h09;
  localparam logic [4:0] A_CUR1   = 5'h0a;
  localparam logic [4:0] A_CUR2   = 5'h0b;
  localparam logic [4:0] A_ZOOM   = 5'h0c;
  localparam logic [4:0] A_TRIDX  = 5'h0d;
  localparam logic [4:0] A_T1TIME = 5'h0e;
  localparam logic [4:0] A_T1VAL  = 5'h0f;
  localparam logic [4:0] A_T2TIME = 5'h10;
  localparam logic [4:0] A_T2VAL  = 5'h11;
  localparam logic [4:0] A_WINDOW = 5'h12;

  localparam int unsigned CTRL_START   = 0;
  localparam int unsigned CTRL_STOP    = 1;
  localparam int unsigned CTRL_DISCARD = 2;
  localparam logic [10:0] MODE_RESET   = 11'h000;
  localparam logic [5:0]  PERIOD_RESET = 6'h06;

  typedef enum logic [1:0] {
    TRIG_FREE   = 2'b00,
    TRIG_SINGLE = 2'b01,
    TRIG_CHAN   = 2'b10
  } trig_mode_t;

  typedef enum logic [1:0] {
    OP_MANUAL = 2'b00,
    OP_MDI    = 2'b01,
    OP_AUTO   = 2'b10
  } op_mode_t;

  typedef enum logic [3:0] {
    SRC_OFF      = 4'h0,
    SRC_V_ACT    = 4'h1,
    SRC_V_NOM    = 4'h2,
    SRC_S_ACT    = 4'h3,
    SRC_S_NOM    = 4'h4,
    SRC_TRAIL    = 4'h5,
    SRC_N_ACT    = 4'h6,
    SRC_N_NOM    = 4'h7,
    SRC_N_INT    = 4'h8,
    SRC_ANALOGUE = 4'h9,
    SRC_SAVED    = 4'ha
  } src_t;

  localparam int unsigned NUM_SRC = 9;

  typedef struct packed {
    logic [2:0] axis;
    src_t       src;
  } chan_cfg_t;

  typedef struct packed {
    trig_mode_t mode;
    logic       falling;
    logic [2:0] pre_code;
    logic [1:0] trig_ch;
    logic       step_sel;
    op_mode_t   op;
  } mode_cfg_t;
endpackage

// ==== design/capture_mem.sv ====
`timescale 1ns/100ps
module capture_mem #(
  parameter int unsigned WIDTH  = 16,
  parameter int unsigned NCH    = 4,
  parameter int unsigned AW     = 12
) (
  input  wire logic                   sys_clk,
  input  wire logic [NCH-1:0]         wr_en,
  input  wire logic [AW-1:0]          wr_idx,
  input  wire logic [NCH*WIDTH-1:0]   wr_data,
  input  wire logic [AW-1:0]          rd_idx_a,
  input  wire logic [AW-1:0]          rd_idx_b,
  output logic      [NCH*WIDTH-1:0]   rd_data_a,
  output logic      [NCH*WIDTH-1:0]   rd_data_b
);
  // one lane per channel so saved lanes keep their contents
  logic [WIDTH-1:0] mem [NCH][2**AW];

  for (genvar c = 0; c < NCH; c++) begin : g_lane
    always_ff @(posedge sys_clk) begin
      if (wr_en[c]) begin
        mem[c][wr_idx] <= wr_data[c*WIDTH +: WIDTH];
      end
    end
    assign rd_data_a[c*WIDTH +: WIDTH] = mem[c][rd_idx_a];
    assign rd_data_b[c*WIDTH +: WIDTH] = mem[c][rd_idx_b];
  end
endmodule

// ==== dv/servo_model.sv ====
`timescale 1ns/100ps
module servo_model #(
  parameter int unsigned NUM_AXES = 5,
  parameter int unsigned DATA_W   = 16
) (
  input  wire logic                                     sys_clk,
  input  wire logic                                     nrst,
  output logic [NUM_AXES*trace_pkg::NUM_SRC*DATA_W-1:0] servo_vals
);
  logic [DATA_W-1:0] ramp_q;
  // sawtooth wraps, so values cross any threshold both ways
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ramp_q <= '0;
    end else begin
      ramp_q <= ramp_q + DATA_W'(257);
    end
  end
  // every source of every axis gets the ramp, offset by 37 per slot
  always_comb begin
    for (int i = 0; i < NUM_AXES * trace_pkg::NUM_SRC; i++) begin
      servo_vals[i*DATA_W +: DATA_W] = ramp_q + DATA_W'(i * 37);
    end
  end
endmodule

// ==== dv/trace_chk.sv ====
`timescale 1ns/100ps
module trace_chk #(
  parameter int unsigned NUM_AXES    = 5,
  parameter int unsigned DATA_W      = 16,
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic                          sys_clk,
  input wire logic                          nrst,
  input wire logic [4:0]                    reg_addr,
  input wire logic [31:0]                   reg_wdata,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [31:0]                   reg_rdata,
  input wire logic [trace_pkg::NUM_CH-1:0]  chan_visible,
  input wire logic [NUM_AXES-1:0]           step_axes,
  input wire logic [DATA_W-1:0]             step_amplitude,
  input wire logic                          recording,
  input wire logic                          sample_strobe
);
  logic [10:0]         mode_q;
  logic [3:0]          src0_q;
  logic [NUM_AXES-1:0] dig_q;
  logic [DATA_W-1:0]   feed_q;
  logic [15:0]         per_q, gap_q, run_q;
  logic [3:0]          age_q;
  wire                 ctrl_wr = reg_wr && reg_addr == trace_pkg::A_CTRL;
  wire [15:0]          per_cyc = per_q * 16'(TICK_CYCLES);
  wire                 step_on = mode_q[1:0] == trace_pkg::OP_MANUAL && mode_q[2];
  // shadow of config; period clamped to the legal range like the block
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mode_q <= trace_pkg::MODE_RESET;
      src0_q <= trace_pkg::SRC_OFF;
      dig_q  <= '0;
      feed_q <= '0;
      per_q  <= 16'(trace_pkg::PERIOD_RESET);
      age_q  <= 4'h0;
      gap_q  <= 16'hffff;
      run_q  <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == trace_pkg::A_MODE) mode_q <= reg_wdata[10:0];
      if (reg_wr && reg_addr == trace_pkg::A_CHCFG0) src0_q <= reg_wdata[7:4];
      if (reg_wr && reg_addr == trace_pkg::A_DIGAX) dig_q <= reg_wdata[NUM_AXES-1:0];
      if (reg_wr && reg_addr == trace_pkg::A_FEED) feed_q <= reg_wdata[DATA_W-1:0];
      if (reg_wr && reg_addr == trace_pkg::A_PERIOD) begin
        per_q <= 16'(reg_wdata[5:0] > trace_pkg::PERIOD_MAX ? trace_pkg::PERIOD_MAX :
                     reg_wdata[5:0] < trace_pkg::PERIOD_MIN ? trace_pkg::PERIOD_MIN :
                     reg_wdata[5:0]);
      end
      age_q <= reg_wr ? 4'h0 : age_q + 4'(age_q != 4'hf);
      gap_q <= sample_strobe ? 16'h0001 : gap_q + 16'(gap_q != 16'hffff);
      run_q <= recording ? run_q + 16'(run_q != 16'hffff) : 16'h0000;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_start; ctrl_wr && reg_wdata[0] |-> ##2 recording; endproperty
  a_start: assert property (p_start) else $error("start ignored");
  property p_stop; ctrl_wr && reg_wdata[1:0] == 2'b10 |-> ##2 !recording; endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  property p_pulse; sample_strobe |=> !sample_strobe; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  property p_gap;
    sample_strobe && gap_q <= run_q |-> gap_q == per_cyc;
  endproperty
  a_gap: assert property (p_gap) else $error("sample spacing off");
  property p_rd_idle;
    !reg_rd || reg_addr > trace_pkg::A_WINDOW |=> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_vis;
    age_q > 4'h2 && src0_q != trace_pkg::SRC_SAVED
      |-> chan_visible[0] == (src0_q != trace_pkg::SRC_OFF);
  endproperty
  a_vis: assert property (p_vis) else $error("channel display wrong");
  property p_hide;
    age_q > 4'h2 && src0_q == trace_pkg::SRC_SAVED && recording && $past(recording)
      |-> !chan_visible[0];
  endproperty
  a_hide: assert property (p_hide) else $error("saved channel shown");
  property p_step; age_q > 4'h2 |-> step_axes == (step_on ? dig_q : '0); endproperty
  a_step: assert property (p_step) else $error("step axes wrong");
  property p_amp;
    age_q > 4'h2 |-> step_amplitude == (step_on ? feed_q : '0);
  endproperty
  a_amp: assert property (p_amp) else $error("step height wrong");
  c_start: cover property (ctrl_wr && reg_wdata[0]);
  c_gap: cover property (sample_strobe && gap_q == per_cyc && gap_q <= run_q);
  c_step: cover property (step_axes != '0);
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  localparam int unsigned NAX = 5;
  localparam int unsigned TK  = 2;
  logic                                 sys_clk, nrst, reg_wr, reg_rd, ext_trigger;
  logic                                 recording, sample_strobe;
  logic [4:0]                           reg_addr;
  logic [31:0]                          reg_wdata, reg_rdata, got, rv;
  logic [NAX*trace_pkg::NUM_SRC*16-1:0] servo_vals;
  logic [3:0]                           chan_visible;
  logic [NAX-1:0]                       step_axes;
  logic [15:0]                          step_amplitude;
  logic [11:0]                          tix;
  logic [5:0]                           per;
  int                                   fails, n_checks, seed, cyc, n, b, b0, th;
  servo_trace_capture #(.NUM_AXES(NAX), .TICK_CYCLES(TK)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .servo_vals(servo_vals),
    .ext_trigger(ext_trigger), .chan_visible(chan_visible), .step_axes(step_axes),
    .step_amplitude(step_amplitude), .recording(recording), .sample_strobe(sample_strobe));
  servo_model #(.NUM_AXES(NAX)) far_end (
    .sys_clk(sys_clk), .nrst(nrst), .servo_vals(servo_vals));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks = n_checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ceiling covers one full 4096-sample capture at the shortest period
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (sample_strobe === 1'b1) n <= n + 1;
    if (cyc == 60000) begin
      fails = fails + 1;
      conclude();
    end
  end
  initial begin
    {nrst, reg_wr, reg_rd, ext_trigger, reg_addr, reg_wdata} = '0;
    {fails, n_checks, cyc, n, got} = '0;
    seed = 53;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(trace_pkg::A_PERIOD);
    chk(got, 32'(trace_pkg::PERIOD_RESET));
    rd(5'h1f);
    chk(got, 32'h0);
    repeat (4) begin
      rv = $random(seed) & 32'h7ff;
      rv[10] = rv[10] & ~rv[9];
      rv[1] = rv[1] & ~rv[0];
      wr(trace_pkg::A_MODE, rv);
      rd(trace_pkg::A_MODE);
      chk(got, rv);
    end
    wr(trace_pkg::A_PERIOD, 32'h3f);
    rd(trace_pkg::A_PERIOD);
    chk(got, 32'h3c);
    for (int z = 0; z < 8; z++) begin
      wr(trace_pkg::A_ZOOM, 32'(z));
      rd(trace_pkg::A_WINDOW);
      chk(got, 32'h1000 >> (z > 6 ? 6 : z));
    end
    for (int op = 0; op < 3; op++) begin
      rv = $random(seed);
      wr(trace_pkg::A_MODE, 32'(op) | 32'h4);
      wr(trace_pkg::A_DIGAX, rv | 32'h1);
      wr(trace_pkg::A_FEED, rv >> 16);
      repeat (3) tick();
      chk(32'(step_axes), op == 0 ? (rv | 32'h1) & 32'h1f : 32'h0);
      chk(32'(step_amplitude), op == 0 ? rv >> 16 : 32'h0);
    end
    wr(trace_pkg::A_MODE, 32'h0);
    wr(trace_pkg::A_CHCFG0, {24'h0, trace_pkg::SRC_SAVED, 4'h1});
    wr(5'h05, {24'h0, trace_pkg::SRC_OFF, 4'h2});
    wr(5'h07, {24'h0, trace_pkg::SRC_ANALOGUE, 4'h4});
    for (int s = 1; s < 10; s++) begin
      wr(5'h06, {24'h0, 4'(s), 4'h3});
      repeat (3) tick();
      chk(32'(chan_visible), 32'hd);
    end
    per = 6'(6 + {$random(seed)} % 55);
    wr(trace_pkg::A_PERIOD, 32'(per));
    wr(trace_pkg::A_CTRL, 32'h1);
    for (int i = 0; i < 300 && sample_strobe !== 1'b1; i++) tick();
    b = cyc;
    tick();
    for (int i = 0; i < 300 && sample_strobe !== 1'b1; i++) tick();
    chk(32'(cyc - b), 32'(per) * TK);
    chk(32'(chan_visible), 32'hc);
    rd(trace_pkg::A_CTRL);
    chk(got & 32'h7, 32'h1);
    wr(trace_pkg::A_CTRL, 32'h2);
    repeat (3) tick();
    chk(32'(recording), 32'h0);
    rd(trace_pkg::A_CTRL);
    chk(got & 32'h7, 32'h2);
    wr(trace_pkg::A_CTRL, 32'h4);
    rd(trace_pkg::A_CTRL);
    chk(got & 32'h7, 32'h0);
    chk(32'(chan_visible), 32'hd);
    // one_trigger_capture, trigger a quarter into the recording
    wr(trace_pkg::A_PERIOD, 32'h6);
    wr(trace_pkg::A_MODE, 32'h220);
    b0 = n;
    wr(trace_pkg::A_CTRL, 32'h1);
    for (int i = 0; i < 20000 && got[2] !== 1'b1; i++) rd(trace_pkg::A_CTRL);
    chk(32'(n - b0), 32'(trace_pkg::QUARTER));
    @(posedge sys_clk);
    ext_trigger <= 1'b1;
    #1 b = n;
    @(posedge sys_clk);
    ext_trigger <= 1'b0;
    for (int i = 0; i < 50000 && recording !== 1'b0; i++) tick();
    repeat (2) tick();
    chk(32'(n - b), 32'(trace_pkg::FULL - trace_pkg::QUARTER));
    chk(32'(n - b0), 32'(trace_pkg::FULL));
    rd(trace_pkg::A_CTRL);
    chk(got & 32'h7, 32'h2);
    rd(trace_pkg::A_TRIDX);
    tix = got[11:0];
    wr(trace_pkg::A_CUR1, {20'h0, tix});
    wr(trace_pkg::A_CUR2, {20'h0, tix[11] ? tix - 12'h5 : tix + 12'h5});
    rd(trace_pkg::A_T1TIME);
    chk(got, 32'h0);
    rd(trace_pkg::A_T2TIME);
    chk(got, tix[11] ? -32'sd30 : 32'sd30);
    // channel trigger on channel 2, rising then falling, no pre-trigger
    for (int f = 0; f < 2; f++) begin
      th = $random(seed) % 16384;
      wr(trace_pkg::A_THRESH, th);
      wr(trace_pkg::A_MODE, 32'h410 | (32'(f) << 8));
      wr(trace_pkg::A_CTRL, 32'h1);
      rd(trace_pkg::A_CTRL);
      chk(got & 32'h7, 32'h5);
      for (int i = 0; i < 600 && got[2] !== 1'b0; i++) rd(trace_pkg::A_CTRL);
      chk(got & 32'h7, 32'h1);
      wr(trace_pkg::A_CTRL, 32'h2);
      rd(trace_pkg::A_TRIDX);
      tix = got[11:0];
      wr(trace_pkg::A_CUR1, {14'h0, 2'h2, 4'h0, tix});
      wr(trace_pkg::A_CUR2, {20'h0, tix - 12'h1});
      rd(trace_pkg::A_T1VAL);
      b = $signed(got[15:0]);
      rd(trace_pkg::A_T2VAL);
      b0 = $signed(16'(got[15:0] + 16'(b)));
      chk(32'(f ? (b0 >= th && b < th) : (b0 < th && b >= th)), 32'h1);
    end
    conclude();
  end
endmodule
bind servo_trace_capture trace_chk #(
  .NUM_AXES(NUM_AXES), .DATA_W(DATA_W), .TICK_CYCLES(TICK_CYCLES)) chk_i (
  .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_visible(chan_visible),
  .step_axes(step_axes), .step_amplitude(step_amplitude), .recording(recording),
  .sample_strobe(sample_strobe));
